// *** design/sfd_pkg.sv ***
// constants, types and field layout for the spi command frame decoder
// assumes one system clock; spi pins arrive already synchronous to it
package sfd_pkg;

    // frame geometry, msb first
    localparam int FRAME_BITS = 32;
    localparam logic [5:0] FRAME_BITS_CNT = 6'h20;
    localparam logic [5:0] CNT_MAX = 6'h3F;
    localparam int CMD_MSB = 31;
    localparam int CMD_LSB = 28;
    localparam int FIX_MSB = 27;
    localparam int FIX_LSB = 24;
    localparam int ADDR_MSB = 23;
    localparam int ADDR_LSB = 16;
    localparam int DATA_MSB = 15;
    localparam int DATA_LSB = 8;
    localparam int SNS_ZERO_MSB = 27;
    localparam int SNS_ZERO_LSB = 8;

    // command codes
    localparam logic [3:0] CODE_UNUSED = 4'h0;
    localparam logic [3:0] CODE_WRITE = 4'h8;
    localparam logic [3:0] CODE_READ = 4'hC;

    // basic status reported in error responses
    localparam logic [1:0] STATUS_ERROR = 2'h3;

    // reset value and crc field filler
    localparam logic [31:0] RESP_RESET = 32'h0000_0000;
    localparam logic [7:0] CRC_PLACEHOLDER = 8'h00;

    typedef enum logic [2:0] {
        SFD_KIND_UNUSED,
        SFD_KIND_SENSOR,
        SFD_KIND_WRITE,
        SFD_KIND_READ,
        SFD_KIND_RESERVED
    } sfd_kind_type;

    // one decoded command
    typedef struct packed {
        sfd_kind_type kind;
        logic [3:0] code;
        logic [2:0] data_source_selector;
        logic [7:0] register_address_field;
        logic [7:0] wdata;
        logic fixed_ok;
    } sfd_cmd_type;

endpackage

// *** design/sfd_frame_shift.sv ***
// serial framing: sclk/cs edge detect, 32-bit receive shift, transmit shift
// assumes sclk, mosi and cs_n are synchronous to sys_clk and slower than half of it
module sfd_frame_shift (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // spi pins
    input wire logic sclk_i,
    input wire logic mosi_i,
    input wire logic cs_n_i,
    output logic miso_o,
    // word to send in the next frame
    input wire logic [31:0] tx_word_i,
    // received frame
    output logic [31:0] rx_word_o,
    output logic [5:0] bit_count_o,
    output logic frame_end_o
);
    logic sclk_q;
    logic cs_n_q;
    logic [31:0] tx_shift;

    // edges; sclk edges only while selected, cs edges always
    wire sclk_rise = sclk_i & ~sclk_q & ~cs_n_i;
    wire sclk_fall = ~sclk_i & sclk_q & ~cs_n_i;
    wire cs_fall = cs_n_q & ~cs_n_i;
    wire cs_rise = ~cs_n_q & cs_n_i;
    wire cnt_sat = (bit_count_o == sfd_pkg::CNT_MAX);

    // pin history for edge detection
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sclk_q <= 1'b0;
            cs_n_q <= 1'b1;
        end else begin
            sclk_q <= sclk_i;
            cs_n_q <= cs_n_i;
        end
    end

    // R1 msb first receive
    // R11 sample on rising edge
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_word_o <= sfd_pkg::RESP_RESET;
            bit_count_o <= 6'h00;
        end else if (cs_fall) begin
            bit_count_o <= 6'h00;
        end else if (sclk_rise) begin
            rx_word_o <= {rx_word_o[30:0], mosi_i};
            bit_count_o <= cnt_sat ? bit_count_o : bit_count_o + 6'h01;
        end
    end

    // R11 change on falling edge
    // miso idles low while deselected; no tristate at this level
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_shift <= sfd_pkg::RESP_RESET;
            miso_o <= 1'b0;
        end else if (cs_fall) begin
            tx_shift <= tx_word_i;
            miso_o <= tx_word_i[sfd_pkg::FRAME_BITS-1];
        end else if (cs_n_i) begin
            miso_o <= 1'b0;
        end else if (sclk_fall) begin
            tx_shift <= {tx_shift[30:0], 1'b0};
            miso_o <= tx_shift[sfd_pkg::FRAME_BITS-2];
        end
    end

    // end of frame marker, one cycle after cs rises
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            frame_end_o <= 1'b0;
        end else begin
            frame_end_o <= cs_rise;
        end
    end

endmodule

// *** design/sfd_decoder.sv ***
// spi command frame decoder top: decode, dispatch pulses, response framing
// assumes spi pins synchronous to sys_clk; register file and sensor data live outside
// What this block does
// R1 - frames are 32 bits, bit 31 shifted first, bit 0 last
// R2 - register frame: code 31:28, zeros 27:24, address 23:16, data 15:8, crc 7:0
// R3 - sensor frame: code 31:28, zeros in 27 down to 8, crc 7:0
// R4 - command code zero is unused, never a valid request
// R5 - odd code is sensor request; code bits 3:1 are the selector
// R6 - code 1000 is a register write with address and data
// R7 - code 1100 is a register read with address
// R8 - sensor request served only by channel whose source id matches selector
// R9 - even codes 0010, 0100, 0110, 1010, 1110 reserved, no action, command error
// R10 - response opens with code bit 0, then bits 3:1, then status 27:26
// R11 - sclk idles low, sample rising, change falling, ignored while deselected
// R12 - register read answered next frame, contents caught at end of command
module sfd_decoder (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // spi pins
    input wire logic sclk_i,
    input wire logic mosi_i,
    input wire logic cs_n_i,
    output logic miso_o,
    // source ids of the two sensor channels
    input wire logic [2:0] source_id0_i,
    input wire logic [2:0] source_id1_i,
    // status and data supplied by the device
    input wire logic [1:0] basic_condition_bits_i,
    input wire logic [15:0] reg_rdata_i,
    input wire logic [17:0] sensor_data0_i,
    input wire logic [17:0] sensor_data1_i,
    // register access requests
    output logic reg_wr_o,
    output logic reg_rd_o,
    output logic [7:0] register_address_field_o,
    output logic [7:0] reg_wdata_o,
    // sensor requests
    output logic sensor_req_o,
    output logic sensor_chan_o,
    output logic [2:0] data_source_selector_o,
    // errors
    output logic cmd_err_o,
    output logic frame_err_o
);
    typedef enum logic [0:0] {SFD_IDLE, SFD_BUILD} sfd_state_type;

    logic rst_meta;
    logic rst_n;
    sfd_state_type state;
    sfd_state_type next_state;
    logic [31:0] rx_word;
    logic [5:0] bit_count;
    logic frame_end;
    logic [31:0] resp_word;
    logic [31:0] next_resp;
    sfd_pkg::sfd_cmd_type held;
    logic held_err;
    logic held_chan;
    logic miso;

    // reset release through two flops
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    sfd_frame_shift u_shift (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n),
        .sclk_i(sclk_i),
        .mosi_i(mosi_i),
        .cs_n_i(cs_n_i),
        .miso_o(miso),
        .tx_word_i(resp_word),
        .rx_word_o(rx_word),
        .bit_count_o(bit_count),
        .frame_end_o(frame_end)
    );

    assign miso_o = miso; // already a flop inside the shifter

    // field extraction
    wire [3:0] code = rx_word[sfd_pkg::CMD_MSB:sfd_pkg::CMD_LSB];
    wire len_ok = (bit_count == sfd_pkg::FRAME_BITS_CNT);
    // R2 register frame zero nibble
    wire reg_fix_ok = (rx_word[sfd_pkg::FIX_MSB:sfd_pkg::FIX_LSB] == 4'h0);
    // R3 sensor frame zero span
    wire sns_fix_ok = (rx_word[sfd_pkg::SNS_ZERO_MSB:sfd_pkg::SNS_ZERO_LSB] == 20'h0_0000);
    // R5 odd code is a sensor request
    wire is_sensor = code[0];
    // R6 write code
    wire is_write = (code == sfd_pkg::CODE_WRITE);
    // R7 read code
    wire is_read = (code == sfd_pkg::CODE_READ);
    // R4 unused code
    wire is_unused = (code == sfd_pkg::CODE_UNUSED);
    // R9 everything else even is reserved
    wire is_reserved = ~is_sensor & ~is_write & ~is_read & ~is_unused;
    wire fix_ok = is_sensor ? sns_fix_ok : reg_fix_ok;
    // R8 channel match against configured source ids
    wire [2:0] selector = code[3:1];
    wire hit0 = (selector == source_id0_i);
    wire hit1 = (selector == source_id1_i);
    wire sns_hit = hit0 | hit1;
    wire valid_cmd = len_ok & fix_ok & (is_sensor ? sns_hit : (is_write | is_read));
    wire sfd_pkg::sfd_kind_type kind = is_sensor ? sfd_pkg::SFD_KIND_SENSOR :
        is_write ? sfd_pkg::SFD_KIND_WRITE :
        is_read ? sfd_pkg::SFD_KIND_READ :
        is_unused ? sfd_pkg::SFD_KIND_UNUSED : sfd_pkg::SFD_KIND_RESERVED;

    // state: build runs one cycle after frame end so read data can settle
    always_comb begin
        next_state = state;
        unique case (state)
            SFD_IDLE: next_state = frame_end ? SFD_BUILD : SFD_IDLE;
            SFD_BUILD: next_state = SFD_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state <= SFD_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // R4 unused and bad frames raise no action
    // R9 reserved codes only flag an error
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            reg_wr_o <= 1'b0;
            reg_rd_o <= 1'b0;
            sensor_req_o <= 1'b0;
            cmd_err_o <= 1'b0;
            frame_err_o <= 1'b0;
        end else begin
            reg_wr_o <= frame_end & valid_cmd & is_write;
            reg_rd_o <= frame_end & valid_cmd & is_read;
            sensor_req_o <= frame_end & valid_cmd & is_sensor;
            cmd_err_o <= frame_end & len_ok & ~valid_cmd;
            frame_err_o <= frame_end & ~len_ok;
        end
    end

    // decoded fields held until the next frame ends
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            held <= '0;
            held_err <= 1'b1;
            held_chan <= 1'b0;
            register_address_field_o <= 8'h00;
            reg_wdata_o <= 8'h00;
            data_source_selector_o <= 3'h0;
            sensor_chan_o <= 1'b0;
        end else if (frame_end) begin
            held <= '{kind, code, selector, rx_word[sfd_pkg::ADDR_MSB:sfd_pkg::ADDR_LSB],
                      rx_word[sfd_pkg::DATA_MSB:sfd_pkg::DATA_LSB], fix_ok};
            held_err <= ~valid_cmd;
            held_chan <= ~hit0;
            register_address_field_o <= rx_word[sfd_pkg::ADDR_MSB:sfd_pkg::ADDR_LSB];
            reg_wdata_o <= rx_word[sfd_pkg::DATA_MSB:sfd_pkg::DATA_LSB];
            data_source_selector_o <= selector;
            sensor_chan_o <= ~hit0; // channel 0 wins when both match
        end
    end

    // R10 echo code bit 0 first, then 3:1, then status
    // R12 read contents caught right after the command frame closes
    always_comb begin
        next_resp = {held.code[0], held.code[3:1], basic_condition_bits_i, 26'h000_0000};
        if (held_err) begin
            next_resp[27:26] = sfd_pkg::STATUS_ERROR;
        end else if (held.kind == sfd_pkg::SFD_KIND_READ) begin
            next_resp[23:8] = reg_rdata_i;
        end else if (held.kind == sfd_pkg::SFD_KIND_WRITE) begin
            next_resp[15:8] = held.wdata;
        end else begin
            next_resp[25:8] = held_chan ? sensor_data1_i : sensor_data0_i;
        end
        next_resp[7:0] = sfd_pkg::CRC_PLACEHOLDER;
    end

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            resp_word <= sfd_pkg::RESP_RESET;
        end else if (state == SFD_BUILD) begin
            resp_word <= next_resp;
        end
    end

    // checks
    AST_WRITE_CODE: assert property (@(posedge sys_clk_i) disable iff (!rst_n) // R6
        reg_wr_o |-> $past(code) == sfd_pkg::CODE_WRITE && $past(len_ok))
        else $error("write pulse without write code");
    AST_READ_CODE: assert property (@(posedge sys_clk_i) disable iff (!rst_n) // R7
        reg_rd_o |-> $past(code) == sfd_pkg::CODE_READ && $past(reg_fix_ok))
        else $error("read pulse without read code");
    AST_SENSOR_SEL: assert property (@(posedge sys_clk_i) disable iff (!rst_n) // R5
        sensor_req_o |-> $past(code[0]) && data_source_selector_o == $past(code[3:1]))
        else $error("sensor request selector wrong");
    AST_SENSOR_MATCH: assert property (@(posedge sys_clk_i) disable iff (!rst_n) // R8
        sensor_req_o |-> data_source_selector_o == $past(source_id0_i) ||
        data_source_selector_o == $past(source_id1_i))
        else $error("sensor served without id match");
    AST_UNUSED_IDLE: assert property (@(posedge sys_clk_i) disable iff (!rst_n) // R4
        frame_end && len_ok && is_unused |=> cmd_err_o && !reg_wr_o && !reg_rd_o && !sensor_req_o)
        else $error("unused code not flagged");
    AST_RESERVED_ERR: assert property (@(posedge sys_clk_i) disable iff (!rst_n) // R9
        frame_end && len_ok && is_reserved |=> cmd_err_o ##0 !(reg_wr_o || sensor_req_o))
        else $error("reserved code not flagged");
    AST_FIXED_ZERO: assert property (@(posedge sys_clk_i) disable iff (!rst_n) // R3
        frame_end && is_sensor && !sns_fix_ok |=> !sensor_req_o)
        else $error("sensor request with nonzero fixed bits");
    AST_LENGTH: assert property (@(posedge sys_clk_i) disable iff (!rst_n) // R1
        frame_end && bit_count != sfd_pkg::FRAME_BITS_CNT |=> frame_err_o && !cmd_err_o)
        else $error("short or long frame not flagged");
    AST_ECHO: assert property (@(posedge sys_clk_i) disable iff (!rst_n) // R10
        state == SFD_BUILD |=> resp_word[31:28] == {held.code[0], held.code[3:1]})
        else $error("response echo wrong");
    AST_READ_DATA: assert property (@(posedge sys_clk_i) disable iff (!rst_n) // R12
        reg_rd_o |=> resp_word[23:8] == $past(reg_rdata_i))
        else $error("read data not captured");
    AST_IDLE_MISO: assert property (@(posedge sys_clk_i) disable iff (!rst_n) // R11
        cs_n_i [*2] |-> !miso_o)
        else $error("miso active while deselected");

    COV_WRITE: cover property (@(posedge sys_clk_i) disable iff (!rst_n) reg_wr_o);
    COV_READ: cover property (@(posedge sys_clk_i) disable iff (!rst_n) reg_rd_o ##[1:200] reg_rd_o);
    COV_SENSOR: cover property (@(posedge sys_clk_i) disable iff (!rst_n)
        sensor_req_o && sensor_chan_o);
    COV_ERR: cover property (@(posedge sys_clk_i) disable iff (!rst_n) cmd_err_o);

endmodule

// *** verification/sfd_host.sv ***
// spi host model: drives command frames and collects the response word
// assumes a 50 MHz system clock; each sclk level lasts several of its cycles
module sfd_host (
    // clock
    input wire logic sys_clk_i,
    // spi pins
    input wire logic miso_i,
    output logic sclk_o,
    output logic mosi_o,
    output logic cs_n_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle levels at time zero
    initial begin
        sclk_o = 1'b0;
        mosi_o = 1'b1;
        cs_n_o = 1'b1;
    end

    task automatic xfer(input logic [39:0] w, input int n, output logic [31:0] r);
        r = 32'h0000_0000;
        @(posedge sys_clk_i);
        cs_n_o <= 1'b0;
        for (int b = n - 1; b >= 0; b--) begin
            repeat (2) @(posedge sys_clk_i);
            mosi_o <= w[b];
            repeat (3) @(posedge sys_clk_i);
            sclk_o <= 1'b1;
            // sampled mid-cycle so the miso flop has settled
            @(negedge sys_clk_i);
            r = {r[30:0], miso_i};
            repeat (3) @(posedge sys_clk_i);
            sclk_o <= 1'b0;
        end
        repeat (3) @(posedge sys_clk_i);
        cs_n_o <= 1'b1;
        mosi_o <= ~mosi_o; // released line shows no stale bit
    endtask

    task automatic idle(input int cyc);
        repeat (cyc) begin
            repeat (2) @(posedge sys_clk_i);
            sclk_o <= ~sclk_o;
            mosi_o <= ~mosi_o;
        end
        @(posedge sys_clk_i);
        sclk_o <= 1'b0;
    endtask
endmodule

// *** verification/spi_command_frame_decoder_test.sv ***
// self-checking bench for the spi command frame decoder
// assumes the host model drives the pins; expectations come from local functions
module spi_command_frame_decoder_test;
    timeunit 1ns;
    timeprecision 1ps;

    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic clr = 1'b0;
    logic sclk, mosi, cs_n, miso;
    logic [2:0] id0 = 3'h0, id1 = 3'h1;
    logic [1:0] cond = 2'h0;
    logic [15:0] rdata = 16'h0000;
    logic [17:0] sd0 = 18'h00000, sd1 = 18'h00000;
    logic wr, rd, sreq, chan, cerr, ferr;
    logic [7:0] addr, wdata;
    logic [2:0] sel;
    logic [1:0] n_wr, n_rd, n_sn, n_ce, n_fe;
    int n_mismatch = 0;
    int cmp_count = 0;
    int seed = 32'he047;

    always #10 sys_clk = ~sys_clk;

    sfd_decoder i_dut (.sys_clk_i(sys_clk), .rstn_i(rstn), .sclk_i(sclk), .mosi_i(mosi),
        .cs_n_i(cs_n), .miso_o(miso), .source_id0_i(id0), .source_id1_i(id1),
        .basic_condition_bits_i(cond), .reg_rdata_i(rdata), .sensor_data0_i(sd0),
        .sensor_data1_i(sd1), .reg_wr_o(wr), .reg_rd_o(rd), .register_address_field_o(addr),
        .reg_wdata_o(wdata), .sensor_req_o(sreq), .sensor_chan_o(chan),
        .data_source_selector_o(sel), .cmd_err_o(cerr), .frame_err_o(ferr));

    sfd_host i_host (.sys_clk_i(sys_clk), .miso_i(miso), .sclk_o(sclk), .mosi_o(mosi),
        .cs_n_o(cs_n));

    // pulse counts per frame; a pulse counts once for each cycle it stays high
    always @(posedge sys_clk) begin
        if (clr) begin
            {n_wr, n_rd, n_sn, n_ce, n_fe} <= 10'h000;
        end else begin
            n_wr <= n_wr + wr;
            n_rd <= n_rd + rd;
            n_sn <= n_sn + sreq;
            n_ce <= n_ce + cerr;
            n_fe <= n_fe + ferr;
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // expected actions {wr, rd, sensor, error, chan} and next response word
    function automatic logic [36:0] model(input logic [31:0] w);
        logic [3:0] c;
        logic hit;
        logic [4:0] a;
        logic [31:0] r;
        c = w[31:28];
        hit = (c[3:1] === id0) || (c[3:1] === id1);
        a = 5'h00;
        r = {c[0], c[3:1], cond, 26'h0};
        if (c[0]) begin
            if (w[27:8] == 20'h00000 && hit) begin
                a = {3'b001, 1'b0, c[3:1] !== id0};
                r[25:8] = (c[3:1] === id0) ? sd0 : sd1;
            end else begin
                a = 5'h02;
            end
        end else if (c == sfd_pkg::CODE_WRITE && w[27:24] == 4'h0) begin
            a = 5'h10;
            r[15:8] = w[15:8];
        end else if (c == sfd_pkg::CODE_READ && w[27:24] == 4'h0) begin
            a = 5'h08;
            r[23:8] = rdata;
        end else begin
            a = 5'h02;
        end
        if (a[1]) r = {c[0], c[3:1], sfd_pkg::STATUS_ERROR, 26'h0};
        return {a, r};
    endfunction

    // bounded run
    initial begin
        repeat (60000) @(posedge sys_clk);
        n_mismatch++;
        end_of_test();
    end

    // every code first, then random frames with two length errors
    initial begin
        logic [31:0] w, r, got, exp_r, mask, e, k;
        logic [36:0] m;
        logic [3:0] c;
        int n;
        exp_r = 32'h0000_0000;
        mask = 32'hFFFF_FFFF;
        repeat (20) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (6) @(posedge sys_clk);
        for (int i = 0; i < 48; i++) begin
            r = $random(seed);
            c = (i < 16) ? 4'(i) : r[7:4];
            w = $random(seed);
            w[31:28] = c;
            if (i < 16 || r[1:0] != 2'h0) begin
                if (c[0]) w[27:8] = 20'h00000;
                else w[27:24] = 4'h0;
            end
            n = (i == 20) ? 31 : (i == 21) ? 33 : 32;
            @(posedge sys_clk);
            id0 <= r[2] ? c[3:1] : 3'($random(seed));
            id1 <= r[3] ? c[3:1] : 3'($random(seed));
            cond <= r[9:8];
            rdata <= r[31:16];
            sd0 <= 18'($random(seed));
            sd1 <= 18'($random(seed));
            clr <= 1'b1;
            @(posedge sys_clk);
            clr <= 1'b0;
            i_host.xfer({8'h00, w}, n, got);
            // a short frame loses the last response bit, a long one shifts in a trailing zero
            k = (n == 31) ? mask >> 1 : (n == 33) ? mask << 1 : mask;
            e = (n == 31) ? exp_r >> 1 : (n == 33) ? exp_r << 1 : exp_r;
            chk(got & k, e & k, "response word");
            repeat (8) @(posedge sys_clk);
            m = model(w);
            if (n != 32) begin
                chk({n_wr, n_rd, n_sn, n_ce, n_fe}, 32'h1, "length error pulses");
                exp_r = {4'h0, sfd_pkg::STATUS_ERROR, 26'h0};
                mask = 32'h0FFF_FFFF;
            end else begin
                chk({n_wr, n_rd, n_sn, n_ce, n_fe}, {1'b0, m[36], 1'b0, m[35], 1'b0, m[34],
                    1'b0, m[33], 2'b00}, "action pulses");
                chk({addr, wdata, sel}, {w[23:16], w[15:8], c[3:1]}, "fields");
                if (m[34]) chk(chan, m[32], "channel");
                exp_r = m[31:0];
                mask = 32'hFFFF_FFFF;
            end
            i_host.idle(8);
            @(negedge sys_clk);
            chk(miso, 1'b0, "miso while deselected");
            $display("test %0d code %h done", i, c);
        end
        end_of_test();
    end
endmodule
